// ---- hw/spi_port.sv ----
// Serial port core: flags, interrupt requests, resets and pin control
`timescale 1ns/1ps

// Behaviour
// - Transmit request needs tx empty, tx irq enable and port enable.
// - Receive request is rx full with rx irq enable, port enable ignored.
// - Error enable lets overflow and mode fault drive the shared request.
// - Status read seeing rx full, then data read, clears rx full.
// - Data write clears tx empty unless the port is disabled or break freezes flags.
// - Byte moving into receive register sets rx full.
// - Byte moving into shift register sets tx empty.
// - System reset returns every part of the port to initial state.
// - Disabled: tx empty set, transfer aborted, shifter cleared, pins freed.
// - Disabling keeps control bits and rx full, overflow, fault flags.
// - Master fault with detection enabled clears port enable.
// - During wait the port runs and its requests still reach the CPU.
// - Stop halts the master engine keeping registers; the slave engine keeps shifting; reset exit aborts and resets.
// - Break without clear enable freezes flags; armed clear completes after.
// - Break with clear enable lets flags clear, and they stay cleared.
// - Data write in break without clear enable does nothing.
// - Slave out pin driven only as slave with slave select low.
// - Enabled port owns direction of data and clock pins.
// - Master drives serial clock; one byte each way in eight clocks.
// - Master shifts out while capturing from its input pin.
// - Wired-OR mode makes the master out pin open drain.
// - Detection disabled never sets the mode fault flag.
// - Overflow set when receive register is unread at bit 1 strobe.
// - Fault: select low as master, or select going high at any time as slave.
module spi_port #(
  parameter int HALF = spi_port_pkg::HALF_PERIOD
) (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       serialClk,
  input  wire logic       ctrlWr,
  input  wire logic       wrPortEnable,
  input  wire logic       wrMasterSelect,
  input  wire logic       wrWiredOrMode,
  input  wire logic       wrTxIrqEnable,
  input  wire logic       wrRxIrqEnable,
  input  wire logic       statusWr,
  input  wire logic       wrErrorIrqEnable,
  input  wire logic       wrFaultDetectEnable,
  input  wire logic       statusRd,
  input  wire logic       dataRd,
  input  wire logic       dataWr,
  input  wire logic [7:0] wrData,
  input  wire logic       waitState,
  input  wire logic       stopState,
  input  wire logic       breakState,
  input  wire logic       breakClearEnable,
  input  wire logic       mosiIn,
  input  wire logic       misoIn,
  input  wire logic       slaveSelectN,
  output logic            serialClkOut,
  output logic            serialClkOe,
  output logic            mosiOut,
  output logic            mosiOe,
  output logic            misoOut,
  output logic            misoOe,
  output logic            pinsOwned,
  output logic            portEnable,
  output logic            masterSelect,
  output logic            txEmptyFlag,
  output logic            rxFullFlag,
  output logic            overflowFlag,
  output logic            modeFaultFlag,
  output logic [7:0]      rxData,
  output logic            txIrq,
  output logic            rxErrIrq
);
  import spi_port_pkg::*;

  if (HALF < 1 || HALF >= (1 << DIV_W)) begin : g_halfCheck
    $error("HALF out of range");
  end

  logic                wiredOrMode;
  logic                txIrqEnable;
  logic                rxIrqEnable;
  logic                errorIrqEnable;
  logic                faultDetectEnable;
  logic [7:0]          txData;
  logic                txReqTog;
  logic                frozen;
  logic                armRx;
  logic                armOvr;
  logic                armFault;
  logic [1:0]          ssSync;
  logic                ssPrev;
  logic [1:0]          misoSync;
  logic                faultCond;
  logic                masterFault;
  master_state_e       mState;
  logic [DIV_W-1:0]    divCnt;
  logic [CNT_W-1:0]    mCnt;
  logic [7:0]          mShift;
  logic [7:0]          mRx;
  logic                mLoad;
  logic                mDone;
  logic                mBit1;
  logic                tick;
  logic                linkClr;
  logic [1:0]          linkReq;
  logic                linkAck;
  logic [CNT_W-1:0]    sCnt;
  logic [7:0]          sShift;
  logic [7:0]          sRxHold;
  logic                sDoneTog;
  logic                sBit1Tog;
  logic [2:0]          ackSync;
  logic [2:0]          doneSync;
  logic [2:0]          bit1Sync;
  logic                sLoad;
  logic                sDone;
  logic                sBit1;
  logic                byteDone;
  logic                bit1Strobe;
  logic                deliver;
  logic                rxClear;
  logic                faultClear;

  // Flags hold still in break unless clearing is allowed
  assign frozen = breakState & ~breakClearEnable;

  // ****************************************
  // Control bits: only system reset clears them; a master fault also clears port enable
  // ****************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      masterSelect      <= RST_MASTER;
      wiredOrMode       <= RST_WIRED_OR;
      txIrqEnable       <= RST_IRQ_EN;
      rxIrqEnable       <= RST_IRQ_EN;
      errorIrqEnable    <= RST_IRQ_EN;
      faultDetectEnable <= RST_FAULT_EN;
    end else begin
      if (ctrlWr) begin
        masterSelect <= wrMasterSelect;
        wiredOrMode  <= wrWiredOrMode;
        txIrqEnable  <= wrTxIrqEnable;
        rxIrqEnable  <= wrRxIrqEnable;
      end
      if (statusWr) begin
        errorIrqEnable    <= wrErrorIrqEnable;
        faultDetectEnable <= wrFaultDetectEnable;
      end
    end
  end

  // Fault wins over a simultaneous software enable
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      portEnable <= RST_PORT_EN;
    end else if (masterFault) begin
      portEnable <= 1'b0;
    end else if (ctrlWr) begin
      portEnable <= wrPortEnable;
    end
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ssSync   <= 2'b11;
      ssPrev   <= 1'b1;
      misoSync <= 2'b00;
    end else begin
      ssSync   <= {ssSync[0], slaveSelectN};
      ssPrev   <= ssSync[1];
      misoSync <= {misoSync[0], misoIn};
    end
  end

  // Slave case assumes select frames each byte
  assign faultCond = portEnable & faultDetectEnable &
                     (masterSelect ? ~ssSync[1]
                                   : (ssSync[1] & ~ssPrev));
  assign masterFault = faultCond & masterSelect;

  // ****************************************
  // Transmit data and empty flag
  // ****************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      txData   <= RST_BYTE;
      txReqTog <= 1'b0;
    end else if (dataWr && !frozen) begin
      txData   <= wrData;
      txReqTog <= ~txReqTog;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      txEmptyFlag <= RST_TX_EMPTY;
    end else if (!portEnable || masterFault) begin
      txEmptyFlag <= 1'b1;
    end else if (mLoad || sLoad) begin
      txEmptyFlag <= 1'b1;
    end else if (dataWr && !frozen) begin
      txEmptyFlag <= 1'b0;
    end
  end

  // ****************************************
  // Master engine on the bus clock
  // ****************************************
  assign tick  = (divCnt == DIV_W'(HALF - 1));
  assign mLoad = (mState == M_IDLE) && portEnable && masterSelect &&
                 !txEmptyFlag && !stopState && !masterFault;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mState       <= M_IDLE;
      divCnt       <= '0;
      mCnt         <= FIRST_BIT;
      mShift       <= RST_BYTE;
      mRx          <= RST_BYTE;
      serialClkOut <= 1'b0;
      mDone        <= 1'b0;
      mBit1        <= 1'b0;
    end else begin
      mDone <= 1'b0;
      mBit1 <= 1'b0;
      if (!portEnable || !masterSelect || masterFault) begin
        mState       <= M_IDLE;
        divCnt       <= '0;
        mCnt         <= FIRST_BIT;
        mShift       <= RST_BYTE;
        serialClkOut <= 1'b0;
      end else if (stopState) begin
        mState <= mState;
      end else begin
        case (mState)
          M_IDLE: begin
            if (mLoad) begin
              mShift <= txData;
              mCnt   <= FIRST_BIT;
              divCnt <= '0;
              mState <= M_SHIFT;
            end
          end
          M_SHIFT: begin
            divCnt <= tick ? '0 : divCnt + 1'b1;
            if (tick && !serialClkOut) begin
              serialClkOut <= 1'b1;
              mRx          <= {mRx[6:0], misoSync[1]};
              mBit1        <= (mCnt == BIT1_STROBE);
            end else if (tick) begin
              serialClkOut <= 1'b0;
              mShift       <= {mShift[6:0], 1'b0};
              mCnt         <= mCnt + 1'b1;
              if (mCnt == LAST_BIT) begin
                mDone  <= 1'b1;
                mState <= M_IDLE;
              end
            end
          end
          default: mState <= M_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Slave engine on the link clock
  // ****************************************
  // Dropping select or enable aborts the byte at once
  assign linkClr = reset | ~portEnable | masterSelect | slaveSelectN;

  always_ff @(posedge serialClk or posedge reset) begin
    if (reset) begin
      linkReq  <= 2'b00;
      linkAck  <= 1'b0;
      sRxHold  <= RST_BYTE;
      sDoneTog <= 1'b0;
      sBit1Tog <= 1'b0;
    end else begin
      linkReq <= {linkReq[0], txReqTog};
      if (!linkClr && sCnt == FIRST_BIT && linkReq[1] != linkAck) begin
        linkAck <= ~linkAck;
      end
      if (!linkClr && sCnt == BIT1_STROBE) begin
        sBit1Tog <= ~sBit1Tog;
      end
      if (!linkClr && sCnt == LAST_BIT) begin
        sRxHold  <= {sShift[6:0], mosiIn};
        sDoneTog <= ~sDoneTog;
      end
    end
  end

  always_ff @(posedge serialClk or posedge linkClr) begin
    if (linkClr) begin
      sCnt   <= FIRST_BIT;
      sShift <= RST_BYTE;
    end else begin
      sCnt   <= sCnt + 1'b1;
      sShift <= (sCnt == FIRST_BIT) ? {txData[6:0], mosiIn}
                                    : {sShift[6:0], mosiIn};
    end
  end

  // Link events back into the bus clock domain
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ackSync  <= 3'b000;
      doneSync <= 3'b000;
      bit1Sync <= 3'b000;
    end else begin
      ackSync  <= {ackSync[1:0], linkAck};
      doneSync <= {doneSync[1:0], sDoneTog};
      bit1Sync <= {bit1Sync[1:0], sBit1Tog};
    end
  end

  assign sLoad = ackSync[2] ^ ackSync[1];
  assign sDone = doneSync[2] ^ doneSync[1];
  assign sBit1 = bit1Sync[2] ^ bit1Sync[1];

  assign byteDone   = mDone | sDone;
  assign bit1Strobe = mBit1 | sBit1;
  // Bytes arriving while overflow stands are dropped
  assign deliver    = byteDone & ~rxFullFlag & ~overflowFlag;

  // ****************************************
  // Receive flags and two-step clears
  // ****************************************
  assign rxClear    = dataRd & ~frozen;
  assign faultClear = ctrlWr & armFault & ~frozen & ~faultCond;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      armRx    <= 1'b0;
      armOvr   <= 1'b0;
      armFault <= 1'b0;
    end else if (!frozen) begin
      if (statusRd) begin
        armRx    <= rxFullFlag;
        armOvr   <= overflowFlag;
        armFault <= modeFaultFlag;
      end else begin
        if (dataRd) begin
          armRx  <= 1'b0;
          armOvr <= 1'b0;
        end
        if (ctrlWr) begin
          armFault <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rxFullFlag <= RST_FLAG;
      rxData     <= RST_BYTE;
    end else if (deliver) begin
      rxFullFlag <= 1'b1;
      rxData     <= mDone ? mRx : sRxHold;
    end else if (rxClear && armRx) begin
      rxFullFlag <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      overflowFlag <= RST_FLAG;
    end else if (bit1Strobe && rxFullFlag && !(rxClear && armRx)) begin
      overflowFlag <= 1'b1;
    end else if (rxClear && armOvr) begin
      overflowFlag <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      modeFaultFlag <= RST_FLAG;
    end else if (faultCond) begin
      modeFaultFlag <= 1'b1;
    end else if (faultClear) begin
      modeFaultFlag <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt requests, live in wait as well
  // ****************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      txIrq    <= 1'b0;
      rxErrIrq <= 1'b0;
    end else begin
      txIrq    <= txEmptyFlag & txIrqEnable & portEnable;
      rxErrIrq <= (rxFullFlag & rxIrqEnable) |
                  (errorIrqEnable &
                   (overflowFlag | modeFaultFlag));
    end
  end

  // ****************************************
  // Pin direction and drive
  // ****************************************
  // Master fault drops portEnable, so pins return to port control
  assign pinsOwned   = portEnable;
  assign serialClkOe = portEnable & masterSelect;
  // Open drain only pulls low, the pullup gives the one
  assign mosiOut     = wiredOrMode ? 1'b0 : mShift[7];
  assign mosiOe      = portEnable & masterSelect &
                       (~wiredOrMode | ~mShift[7]);
  assign misoOut     = (sCnt == FIRST_BIT) ? txData[7] : sShift[7];
  assign misoOe      = portEnable & ~masterSelect & ~ssSync[1];

endmodule

// ---- hw/spi_port_pkg.sv ----
// Shared constants for the serial port block
package spi_port_pkg;

  // ********************************
  // Widths and bit positions
  // ********************************
  localparam int          BYTE_BITS    = 8;
  localparam int          CNT_W        = 3;
  localparam logic [2:0]  LAST_BIT     = 3'h7;
  // Bit 1 is captured on the seventh serial clock
  localparam logic [2:0]  BIT1_STROBE  = 3'h6;
  localparam logic [2:0]  FIRST_BIT    = 3'h0;

  // ********************************
  // Reset values
  // ********************************
  localparam logic        RST_PORT_EN  = 1'b0;
  localparam logic        RST_MASTER   = 1'b1;
  localparam logic        RST_WIRED_OR = 1'b0;
  localparam logic        RST_IRQ_EN   = 1'b0;
  localparam logic        RST_FAULT_EN = 1'b0;
  localparam logic        RST_TX_EMPTY = 1'b1;
  localparam logic        RST_FLAG     = 1'b0;
  localparam logic [7:0]  RST_BYTE     = 8'h00;

  // ********************************
  // Timing
  // ********************************
  // Master serial clock half period, in bus clocks
  localparam int          HALF_PERIOD  = 2;
  localparam int          DIV_W        = 8;

  // ********************************
  // Master engine states
  // ********************************
  typedef enum logic {
    M_IDLE,
    M_SHIFT
  } master_state_e;

endpackage

// ---- tb/spi_far_end.sv ----
// Remote slave answering the master link
`timescale 1ns/1ps
module spi_far_end (
  input  wire logic       sck,
  input  wire logic       sckOe,
  input  wire logic       mosi,
  output logic            miso,
  output logic [7:0]      got
);
  // ****************
  // Reply stream
  // ****************
  // New reply per byte so a stale receive register shows up
  logic [7:0] reply = 8'h3C;
  logic [2:0] pos = 3'h0;
  always @(posedge sck) begin
    got <= {got[6:0], mosi};
  end
  always @(negedge sck or negedge sckOe) begin
    if (!sckOe) begin
      pos <= 3'h0;
    end else begin
      pos <= pos + 3'h1;
      if (pos == 3'h7) begin
        reply <= reply + 8'h11;
      end
    end
  end
  // Released line shows the inverse, never a held bit
  assign miso = sckOe ? reply[~pos] : ~reply[~pos];
endmodule

// ---- tb/spi_port_assertions.sv ----
// Concurrent checks on the serial port core's ports
`timescale 1ns/1ps
module spi_port_assertions (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ctrlWr,
  input wire logic dataWr,
  input wire logic dataRd,
  input wire logic breakState,
  input wire logic breakClearEnable,
  input wire logic slaveSelectN,
  input wire logic serialClkOe,
  input wire logic mosiOe,
  input wire logic misoOe,
  input wire logic pinsOwned,
  input wire logic portEnable,
  input wire logic masterSelect,
  input wire logic txEmptyFlag,
  input wire logic rxFullFlag,
  input wire logic overflowFlag,
  input wire logic modeFaultFlag,
  input wire logic txIrq,
  input wire logic rxErrIrq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  // ****************
  // Port checks
  // ****************
  a_tx_irq_gate: assert property (txIrq |->
      $past(txEmptyFlag && portEnable))
    else $error("tx request without empty flag and enable");
  a_rx_irq_src: assert property (rxErrIrq |->
      $past(rxFullFlag || overflowFlag || modeFaultFlag))
    else $error("rx request without a set flag");
  a_tx_write_clr: assert property (dataWr && txEmptyFlag &&
      portEnable && !ctrlWr && !breakState |=> !txEmptyFlag)
    else $error("data write left tx empty set");
  a_off_tx_empty: assert property (!portEnable &&
      !ctrlWr && !dataWr |=> txEmptyFlag)
    else $error("disabled port lost tx empty");
  a_off_pins_free: assert property (!portEnable &&
      $past(!portEnable) |-> !serialClkOe && !mosiOe && !misoOe)
    else $error("disabled port drives a pin");
  a_pins_owned: assert property (pinsOwned == portEnable)
    else $error("pin ownership differs from enable");
  a_miso_slave: assert property (misoOe |->
      portEnable && !masterSelect)
    else $error("slave out driven outside slave mode");
  a_miso_desel: assert property (slaveSelectN [*3] |-> !misoOe)
    else $error("slave out driven while deselected");
  a_clk_master: assert property (serialClkOe |->
      masterSelect && portEnable)
    else $error("serial clock driven outside master mode");
  a_fault_off: assert property ($rose(modeFaultFlag) &&
      masterSelect |-> !portEnable)
    else $error("master fault left port enabled");
  a_break_wr: assert property (breakState && !breakClearEnable &&
      dataWr && txEmptyFlag |=> txEmptyFlag)
    else $error("data write in break took effect");
  a_rx_clear: assert property ($fell(rxFullFlag) |->
      $past(dataRd && !(breakState && !breakClearEnable)))
    else $error("rx full cleared without allowed data read");
  a_ovf_hold: assert property ($rose(rxFullFlag) |->
      !$past(overflowFlag))
    else $error("byte delivered while overflow set");
endmodule

bind spi_port spi_port_assertions spi_port_assertions_i (.mclk, .reset,
  .ctrlWr, .dataWr, .dataRd, .breakState, .breakClearEnable, .slaveSelectN,
  .serialClkOe, .mosiOe, .misoOe, .pinsOwned, .portEnable, .masterSelect,
  .txEmptyFlag, .rxFullFlag, .overflowFlag, .modeFaultFlag, .txIrq,
  .rxErrIrq);

// ---- tb/spi_port_bench.sv ----
// Directed bench for the serial port core
`timescale 1ns/1ps
module spi_port_bench;
  logic mclk = 0, reset = 0, serialClk = 0, ctrlWr = 0, statusWr = 0;
  logic wrPortEnable = 0, wrMasterSelect = 0, wrTxIrqEnable = 0;
  logic wrRxIrqEnable = 0, wrErrorIrqEnable = 0, wrFaultDetectEnable = 0;
  logic statusRd = 0, dataRd = 0, dataWr = 0, waitState = 0;
  logic breakState = 0, breakClearEnable = 0, mosiIn = 0;
  logic slaveSelectN = 1, misoIn, wrWiredOrMode = 0, stopState = 0;
  logic [7:0] wrData = 8'h00, rxData, farGot, seen;
  logic serialClkOut, serialClkOe, mosiOut, mosiOe, misoOut, misoOe;
  logic pinsOwned, portEnable, masterSelect, txEmptyFlag, rxFullFlag;
  logic overflowFlag, modeFaultFlag, txIrq, rxErrIrq;
  int   err_total = 0, samples_checked = 0, cycles = 0;

  spi_port #(.HALF(4)) spi_port_i (.mclk, .reset, .serialClk, .ctrlWr,
    .wrPortEnable, .wrMasterSelect, .wrWiredOrMode, .wrTxIrqEnable,
    .wrRxIrqEnable, .statusWr, .wrErrorIrqEnable, .wrFaultDetectEnable,
    .statusRd, .dataRd, .dataWr, .wrData, .waitState, .stopState,
    .breakState, .breakClearEnable, .mosiIn, .misoIn, .slaveSelectN,
    .serialClkOut, .serialClkOe, .mosiOut, .mosiOe, .misoOut, .misoOe,
    .pinsOwned, .portEnable, .masterSelect, .txEmptyFlag, .rxFullFlag,
    .overflowFlag, .modeFaultFlag, .rxData, .txIrq, .rxErrIrq);
  // Pull-up holds a released data line high
  spi_far_end spi_far_end_i (.sck(serialClkOut), .sckOe(serialClkOe),
    .mosi(mosiOe ? mosiOut : 1'b1), .miso(misoIn), .got(farGot));

  // ****************
  // Access tasks
  // ****************
  task automatic tick(int n = 1);
    repeat (n) @(posedge mclk);
    #5;
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    tick();
    s = 0;
  endtask
  task automatic setCtrl(logic en, ms, txie, rxie);
    {wrPortEnable, wrMasterSelect, wrTxIrqEnable, wrRxIrqEnable} =
      {en, ms, txie, rxie};
    pulse(ctrlWr);
  endtask
  task automatic setStat(logic ee, fe);
    {wrErrorIrqEnable, wrFaultDetectEnable} = {ee, fe};
    pulse(statusWr);
  endtask
  task automatic wrByte(logic [7:0] b);
    wrData = b;
    pulse(dataWr);
  endtask
  task automatic waitRx;
    for (int k = 0; k < 300 && rxFullFlag !== 1'b1; k++) tick();
  endtask
  // Link clock runs inside this call and in the slave test's two pre-select pulses, 6 ns period
  task automatic slaveByte(logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      mosiIn = b[i];
      // Remote master takes the bit standing before the edge
      seen = {seen[6:0], misoOut};
      #3 serialClk = 1;
      #3 serialClk = 0;
    end
    mosiIn = ~b[0];
  endtask
  task automatic cmp8(string n, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cmp1(string n, logic e, logic g);
    cmp8(n, {7'h00, e}, {7'h00, g});
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    forever #50 mclk = ~mclk;
  end
  // Whole run is under 1500 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      complete_run();
    end
  end

  // ****************
  // Tests
  // ****************
  // Flag vector: enable, master, txE, rxF, ovf, fault, txIrq, rxIrq
  initial begin
    // Raised after time zero so the async reset edge is seen
    #1 reset = 1;
    tick(5);
    reset = 0;
    cmp8("reset flags", 8'h60, {portEnable, masterSelect, txEmptyFlag,
      rxFullFlag, overflowFlag, modeFaultFlag, txIrq, rxErrIrq});
    cmp8("reset data", 8'h00, rxData);
    $display("test reset done");
    waitState = 1;
    setCtrl(1, 1, 1, 1);
    tick();
    cmp1("tx irq", 1, txIrq);
    wrByte(8'hA5);
    cmp1("tx empty", 0, txEmptyFlag);
    waitRx();
    cmp8("rx data", 8'h3C, rxData);
    cmp8("far got", 8'hA5, farGot);
    cmp1("tx reload", 1, txEmptyFlag);
    tick();
    cmp1("rx irq", 1, rxErrIrq);
    waitState = 0;
    $display("test master byte done");
    pulse(statusRd);
    breakState = 1;
    pulse(dataRd);
    wrByte(8'h77);
    cmp8("break", 8'hC0, {txEmptyFlag, rxFullFlag, 6'h00});
    breakState = 0;
    pulse(dataRd);
    cmp1("rx cleared", 0, rxFullFlag);
    $display("test break done");
    setCtrl(1, 1, 1, 0);
    setStat(1, 0);
    wrByte(8'h11);
    waitRx();
    cmp8("rx data 2", 8'h4D, rxData);
    tick();
    cmp1("rx irq off", 0, rxErrIrq);
    wrByte(8'h22);
    for (int k = 0; k < 300 && overflowFlag !== 1'b1; k++) tick();
    cmp1("overflow", 1, overflowFlag);
    tick(60);
    cmp1("err irq", 1, rxErrIrq);
    cmp8("rx kept", 8'h4D, rxData);
    cmp8("far got 2", 8'h22, farGot);
    $display("test overflow done");
    setCtrl(0, 1, 1, 0);
    tick();
    cmp8("disable", 8'h79, {portEnable, masterSelect, txEmptyFlag,
      rxFullFlag, overflowFlag, modeFaultFlag, txIrq, rxErrIrq});
    cmp1("clk oe", 0, serialClkOe);
    pulse(statusRd);
    pulse(dataRd);
    cmp8("cleared", 8'h00, {rxFullFlag, overflowFlag, 6'h00});
    $display("test disable done");
    wrWiredOrMode = 1;
    stopState = 1;
    setCtrl(1, 1, 0, 0);
    wrByte(8'hA3);
    tick(20);
    cmp1("stop hold", 0, txEmptyFlag);
    stopState = 0;
    tick(2);
    cmp8("wired pin", 8'h00, {mosiOe, mosiOut, 6'h00});
    waitRx();
    cmp8("far got 3", 8'hA3, farGot);
    cmp8("rx data 3", 8'h6F, rxData);
    breakState = 1;
    breakClearEnable = 1;
    pulse(statusRd);
    pulse(dataRd);
    breakState = 0;
    tick();
    cmp1("break clear", 0, rxFullFlag);
    wrWiredOrMode = 0;
    $display("test stop and wired done");
    setStat(0, 0);
    setCtrl(1, 1, 0, 0);
    slaveSelectN = 0;
    tick(4);
    cmp1("no fault", 0, modeFaultFlag);
    slaveSelectN = 1;
    tick(3);
    setStat(0, 1);
    slaveSelectN = 0;
    tick(4);
    cmp8("fault", 8'hC0, {modeFaultFlag, ~portEnable, 6'h00});
    slaveSelectN = 1;
    tick(3);
    pulse(statusRd);
    setCtrl(0, 1, 0, 0);
    cmp1("fault cleared", 0, modeFaultFlag);
    $display("test master fault done");
    setCtrl(1, 0, 0, 1);
    tick(3);
    cmp1("miso idle", 0, misoOe);
    wrByte(8'h81);
    repeat (2) begin
      #3 serialClk = 1;
      #3 serialClk = 0;
    end
    slaveSelectN = 0;
    tick(3);
    cmp1("miso on", 1, misoOe);
    slaveByte(8'h5A);
    waitRx();
    cmp8("slave rx", 8'h5A, rxData);
    cmp8("slave tx", 8'h81, seen);
    slaveSelectN = 1;
    tick(4);
    cmp8("slave fault", 8'hC0, {modeFaultFlag, portEnable, misoOe,
      5'h00});
    $display("test slave done");
    reset = 1;
    tick();
    cmp8("rereset", 8'h60, {portEnable, masterSelect, txEmptyFlag,
      rxFullFlag, overflowFlag, modeFaultFlag, txIrq, rxErrIrq});
    reset = 0;
    $display("test second reset done");
    complete_run();
  end
endmodule
